/* bcg_cfg.svh */
/*
  bcg_cfg.svh: offsets, field positions, reset values and timing counts
  for the base clock generator. Assumes inclusion by bare name.
*/
`ifndef BCG_CFG_SVH
`define BCG_CFG_SVH

// register byte offsets (word index times four)
`define BCG_OFS_OUTSEL0   8'h00
`define BCG_OFS_DIVSEL0   8'h30
`define BCG_OFS_PLL_CTRL  8'h4c
`define BCG_OFS_PLL_STAT  8'h50
`define BCG_OFS_PRESENCE  8'h54
`define BCG_OFS_EVENT     8'h58
`define BCG_OFS_IDENT     8'h5c

// source select field
`define BCG_SEL_LSB       0
`define BCG_SEL_W         4
// fractional divider fields
`define BCG_DIV_L_LSB     8
`define BCG_DIV_D_LSB     16

// pll control fields
`define BCG_PLL_PD_BIT    0
`define BCG_PLL_P23_BIT   1
`define BCG_PLL_DIR_BIT   2
`define BCG_PLL_PSEL_LSB  3
`define BCG_PLL_M_LSB     8

// reset value of the pll control word: powered down
`define BCG_PLL_CTRL_RST  32'h0000_0001

// timing
`define BCG_DET_LIMIT     32
`define BCG_FALL_LIMIT    32
`define BCG_LOCK_NS       100000
`define BCG_CLK_NS        50
`define BCG_HOLD_CYC      4

`endif

/* bcg_pkg.sv */
/*
  bcg_pkg: types of the base clock generator.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bcg_pkg;

  // source codes seen by every selector
  typedef enum logic [3:0] {
    BCG_SRC_RING  = 4'h0,
    BCG_SRC_XTAL  = 4'h1,
    BCG_SRC_PLL0  = 4'h2,
    BCG_SRC_PLL1  = 4'h3,
    BCG_SRC_PLL2  = 4'h4,
    BCG_SRC_DIV0  = 4'h5,
    BCG_SRC_DIV6  = 4'hb
  } bcg_src_t;

  // switch sequencer
  typedef enum logic [3:0] {
    BCG_SW_RUN   = 4'b0001,
    BCG_SW_FALL  = 4'b0010,
    BCG_SW_HOLD  = 4'b0100,
    BCG_SW_WAKE  = 4'b1000
  } bcg_sw_t;

endpackage

/* bcg_detector.sv */
/*
  bcg_detector: activity detector for one clock source, sampled as data.
  Assumes mon_i is already synchronous to clk_i (control base clock).
*/
`timescale 1ns/10ps
`include "bcg_cfg.svh"

module bcg_detector
  import bcg_pkg::*;
#(
  parameter int LIMIT = `BCG_DET_LIMIT
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // monitored level
  input  wire logic mon_i,
  // state
  output logic      active_o,
  output logic      rise_o,
  output logic      fall_o
);

  initial begin
    if (LIMIT < 2 || LIMIT > 255) $error("bcg_detector: bad LIMIT");
  end

  logic [7:0] cnt_reg, cnt_next;
  logic       prev_reg, prev_next;
  logic       act_reg, act_next;
  logic       rise_reg, rise_next;
  logic       fall_reg, fall_next;
  logic       edge_seen;

  always_comb begin
    edge_seen = mon_i & ~prev_reg;
    prev_next = mon_i;
    cnt_next  = cnt_reg;
    act_next  = act_reg;
    rise_next = 1'b0;
    fall_next = 1'b0;
    if (edge_seen) begin
      cnt_next = 8'h00;
      act_next = 1'b1;
      rise_next = ~act_reg;
    end else if (cnt_reg == 8'(LIMIT - 1)) begin
      // no rising edge within the window: absent
      act_next  = 1'b0;
      fall_next = act_reg;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // absent after reset until proven otherwise
      cnt_reg  <= 8'h00;
      prev_reg <= 1'b0;
      act_reg  <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      prev_reg <= prev_next;
      act_reg  <= act_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign active_o = act_reg;
  assign rise_o   = rise_reg;
  assign fall_o   = fall_reg;

  property p_det_drop;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!mon_i) [*8] |-> ##[0:40] !act_reg || mon_i;
  endproperty
  a_det_drop: assert property (p_det_drop)
    else $error("detector kept active without edges");

  property p_det_rise;
    @(posedge clk_i) disable iff (!rst_n_i)
      (mon_i && !prev_reg) |=> act_reg;
  endproperty
  a_det_rise: assert property (p_det_rise)
    else $error("detector missed a rising edge");

endmodule

/* bcg_switch.sv */
/*
  bcg_switch: glitch-free source switch for one generator, clocks as data.
  Assumes sources are levels sampled at clk_i; sel_pll_i marks a pll source.
*/
`timescale 1ns/10ps
`include "bcg_cfg.svh"

module bcg_switch
  import bcg_pkg::*;
#(
  parameter int NSRC      = 12,
  parameter int LOCK_CYC  = 2000
) (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // sources and request
  input  wire logic [NSRC-1:0] src_i,
  input  wire logic [3:0]      sel_i,
  input  wire logic            sel_pll_i,
  input  wire logic            pll_lock_i,
  // output
  output logic                 clk_o,
  output logic                 busy_o
);

  initial begin
    if (NSRC < 1 || NSRC > 16) $error("bcg_switch: bad NSRC");
    if (LOCK_CYC < 1 || LOCK_CYC > 65535) $error("bcg_switch: bad LOCK_CYC");
  end

  bcg_sw_t     st_reg, st_next;
  logic [3:0]  cur_reg, cur_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        out_reg, out_next;
  logic        lvl;

  always_comb begin
    lvl      = src_i[cur_reg];
    st_next  = st_reg;
    cur_next = cur_reg;
    cnt_next = cnt_reg;
    out_next = 1'b0;
    case (st_reg)
      BCG_SW_RUN: begin
        out_next = lvl;
        if (sel_i != cur_reg) begin
          st_next  = BCG_SW_FALL;
          cnt_next = 16'h0000;
          out_next = lvl & out_reg;
        end
      end
      BCG_SW_FALL: begin
        // wait for the old clock low; force low if it hangs
        out_next = lvl & out_reg;
        cnt_next = cnt_reg + 16'h0001;
        if (!lvl || cnt_reg == 16'(`BCG_FALL_LIMIT - 1)) begin
          out_next = 1'b0;
          cur_next = sel_i;
          cnt_next = 16'h0000;
          st_next  = BCG_SW_HOLD;
        end
      end
      BCG_SW_HOLD: begin
        // held low: short for plain sources, until lock for pll
        cnt_next = cnt_reg + 16'h0001;
        if (sel_pll_i) begin
          if (pll_lock_i && cnt_reg >= 16'(LOCK_CYC - 1)) begin
            st_next = BCG_SW_WAKE;
          end
        end else if (cnt_reg >= 16'(`BCG_HOLD_CYC - 1)) begin
          st_next = BCG_SW_WAKE;
        end
      end
      BCG_SW_WAKE: begin
        // resume only on a low level so first pulse is whole
        if (!lvl) begin
          st_next = BCG_SW_RUN;
        end
      end
      default: begin
        st_next = BCG_SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg  <= BCG_SW_RUN;
      cur_reg <= 4'h0;
      cnt_reg <= 16'h0000;
      out_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      cur_reg <= cur_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign clk_o  = out_reg;
  assign busy_o = (st_reg != BCG_SW_RUN);

  property p_sw_low;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_reg == BCG_SW_HOLD) |=> !out_reg;
  endproperty
  a_sw_low: assert property (p_sw_low)
    else $error("output not low during hold");

  property p_sw_force;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_reg == BCG_SW_FALL) |-> ##[1:33] (st_reg != BCG_SW_FALL);
  endproperty
  a_sw_force: assert property (p_sw_force)
    else $error("switch stuck waiting for fall");

endmodule

/* bcg_top.sv */
/*
  bcg_top: base clock generator with source selectors, activity
  detection, pll control and avalon-mm register slave.
  Assumes clk_i is the control base clock and that all source clocks are
  presented as levels sampled on it; the analog pll and oscillators sit
  outside, this block drives their controls and reads their levels.
*/
// Register access over Avalon-MM and the register addresses are this design's own decisions.
// Notes on behaviour
// - outputs 0..11, 10 reserved, 0 and 2 ring
// - safe and control clocks use ring only
// - ring oscillator never powered down
// - others pick divider, pll phase, ring, crystal
// - dividers take pll phase, ring or crystal
// - pll input is the crystal oscillator
// - invalid source kept, other fields still written
// - reset selects ring oscillator everywhere
// - selects of inactive clocks are not stored
// - per-source presence status and change events
// - no edge in 32 control cycles: inactive
// - all absent after reset, valid after 32
// - dead selected source kept, event still raised
// - glitch-free switch, output held low briefly
// - pll switch held low until lock
// - stuck high over 32 cycles forced low
// - feedback divider m and lock indication
// - extra phase enable turns on two phases
// - direct bypasses, else divide by 2..16
// - power-down stops pll, lock low
// - three pll phases 0, 120, 240 degrees
`timescale 1ns/10ps
`include "bcg_cfg.svh"

module bcg_top
  import bcg_pkg::*;
#(
  parameter int          NOUT     = 12,
  parameter int          NDIV     = 7,
  parameter int          LOCK_CYC = (`BCG_LOCK_NS + `BCG_CLK_NS - 1)
                                    / `BCG_CLK_NS,
  parameter logic [31:0] IDENT    = 32'h0000_5a01 // arbitrary value
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // source levels
  input  wire logic        ring_clk_i,
  input  wire logic        xtal_clk_i,
  input  wire logic [2:0]  pll_phase_i,
  input  wire logic [6:0]  div_clk_i,
  input  wire logic        pll_lock_i,
  // pll and ring oscillator controls
  output logic             pll_power_down_o,
  output logic             extra_phase_enable_o,
  output logic             pll_direct_o,
  output logic [1:0]       pll_post_sel_o,
  output logic [7:0]       pll_fb_div_o,
  output logic             ring_power_down_o,
  // divider controls
  output logic [6:0][3:0]  div_src_o,
  output logic [6:0][7:0]  div_l_o,
  output logic [6:0][7:0]  div_d_o,
  // base clocks
  output logic [11:0]      base_clk_o
);

  initial begin
    if (NOUT != 12) $error("bcg_top: NOUT must be 12");
    if (NDIV != 7) $error("bcg_top: NDIV must be 7");
  end

  localparam int NSRC = 12;

  // source vector in select-code order
  logic [NSRC-1:0] src_lvl;
  logic [NSRC-1:0] src_act, src_rise, src_fall;
  assign src_lvl = {div_clk_i, pll_phase_i, xtal_clk_i, ring_clk_i};

  // one detector per source
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_det
      bcg_detector #(.LIMIT(`BCG_DET_LIMIT)) u_det (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .mon_i   (src_lvl[g]),
        .active_o(src_act[g]),
        .rise_o  (src_rise[g]),
        .fall_o  (src_fall[g])
      );
    end
  endgenerate

  // register state
  logic [NOUT-1:0][3:0] osel_reg, osel_next;
  logic [NDIV-1:0][3:0] dsel_reg, dsel_next;
  logic [NDIV-1:0][7:0] dl_reg, dl_next, dd_reg, dd_next;
  logic [31:0]          pll_reg, pll_next;
  logic [23:0]          evt_reg, evt_next;
  logic [31:0]          rd_reg, rd_next;
  logic                 ack_reg, ack_next;
  logic                 wait_reg, wait_next;
  logic                 ring_pd_reg, ring_pd_next;
  logic [NOUT-1:0]      bclk;
  logic [NOUT-1:0]      sw_busy;

  // legality of a select code for an output or a divider
  // masks only at write time: a source that dies later stays selected
  function automatic logic sel_ok(input logic [3:0] s, input logic is_div,
                                  input logic [NSRC-1:0] act);
    logic ok;
    ok = 1'b0;
    if (s < 4'(NSRC)) begin
      ok = act[s];
    end
    if (is_div && s >= BCG_SRC_DIV0) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  logic [3:0] widx;
  logic       acc, wr_now;
  logic [31:0] wd;

  always_comb begin
    osel_next = osel_reg;
    dsel_next = dsel_reg;
    dl_next   = dl_reg;
    dd_next   = dd_reg;
    pll_next  = pll_reg;
    evt_next  = evt_reg | {src_fall, src_rise};
    rd_next   = rd_reg;
    acc       = (avs_read | avs_write) & ~ack_reg;
    ack_next  = acc;
    wait_next = ~acc;
    // constant, but kept in a flop so the pin comes from a register
    ring_pd_next = 1'b0;
    wr_now    = avs_write & ~ack_reg;
    widx      = 4'h0;
    wd        = avs_writedata;
    if (wr_now) begin
      if (avs_address < `BCG_OFS_DIVSEL0) begin
        widx = avs_address[5:2];
        // safe, control and reserved outputs stay on ring
        if (widx != 4'd0 && widx != 4'd2 && widx != 4'd10 &&
            avs_byteenable[0] &&
            sel_ok(wd[3:0], 1'b0, src_act)) begin
          osel_next[widx] = wd[3:0];
        end
      end else if (avs_address < `BCG_OFS_PLL_CTRL) begin
        widx = 4'((avs_address - `BCG_OFS_DIVSEL0) >> 2);
        if (avs_byteenable[0] && sel_ok(wd[3:0], 1'b1, src_act)) begin
          dsel_next[widx] = wd[3:0];
        end
        if (avs_byteenable[1]) begin
          dl_next[widx] = wd[`BCG_DIV_L_LSB +: 8];
        end
        if (avs_byteenable[2]) begin
          dd_next[widx] = wd[`BCG_DIV_D_LSB +: 8];
        end
      end else if (avs_address == `BCG_OFS_PLL_CTRL) begin
        // pll source is fixed to crystal: no select field exists
        if (avs_byteenable[0]) begin
          pll_next[7:0] = wd[7:0];
        end
        if (avs_byteenable[1]) begin
          pll_next[15:8] = wd[15:8];
        end
      end else if (avs_address == `BCG_OFS_EVENT) begin
        // write one to clear; a new event in the same cycle wins
        evt_next = (evt_reg & ~wd[23:0]) | {src_fall, src_rise};
      end
    end
    if (avs_read & ~ack_reg) begin
      rd_next = 32'h0000_0000;
      if (avs_address < `BCG_OFS_DIVSEL0) begin
        rd_next[3:0] = osel_reg[avs_address[5:2]];
      end else if (avs_address < `BCG_OFS_PLL_CTRL) begin
        widx = 4'((avs_address - `BCG_OFS_DIVSEL0) >> 2);
        rd_next = {8'h00, dd_reg[widx], dl_reg[widx], 4'h0, dsel_reg[widx]};
      end else if (avs_address == `BCG_OFS_PLL_CTRL) begin
        rd_next = pll_reg;
      end else if (avs_address == `BCG_OFS_PLL_STAT) begin
        // lock reads low in power-down
        rd_next = {30'h0, |sw_busy, pll_lock_i & ~pll_reg[`BCG_PLL_PD_BIT]};
      end else if (avs_address == `BCG_OFS_PRESENCE) begin
        rd_next = {20'h0, src_act};
      end else if (avs_address == `BCG_OFS_EVENT) begin
        rd_next = {8'h0, evt_reg};
      end else if (avs_address == `BCG_OFS_IDENT) begin
        rd_next = IDENT;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osel_reg <= '0;
      dsel_reg <= '0;
      dl_reg   <= '0;
      dd_reg   <= '0;
      pll_reg  <= `BCG_PLL_CTRL_RST;
      evt_reg  <= '0;
      rd_reg   <= '0;
      ack_reg  <= 1'b0;
      wait_reg <= 1'b1;
      ring_pd_reg <= 1'b0;
    end else begin
      osel_reg <= osel_next;
      dsel_reg <= dsel_next;
      dl_reg   <= dl_next;
      dd_reg   <= dd_next;
      pll_reg  <= pll_next;
      evt_reg  <= evt_next;
      rd_reg   <= rd_next;
      ack_reg  <= ack_next;
      wait_reg <= wait_next;
      ring_pd_reg <= ring_pd_next;
    end
  end

  assign avs_readdata    = rd_reg;
  assign avs_waitrequest = wait_reg;

  // one glitch-free switch per output; 0, 2 and 10 never leave ring
  generate
    for (g = 0; g < NOUT; g++) begin : g_sw
      logic [3:0] sel_l;
      assign sel_l = osel_reg[g];
      bcg_switch #(.NSRC(NSRC), .LOCK_CYC(LOCK_CYC)) u_sw (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .src_i     (src_lvl),
        .sel_i     (sel_l),
        .sel_pll_i (sel_l >= BCG_SRC_PLL0 && sel_l <= BCG_SRC_PLL2),
        .pll_lock_i(pll_lock_i & ~pll_reg[`BCG_PLL_PD_BIT]),
        .clk_o     (bclk[g]),
        .busy_o    (sw_busy[g])
      );
    end
  endgenerate

  // registered pin outputs
  logic [11:0] bclk_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bclk_reg <= '0;
    end else begin
      bclk_reg <= bclk & ~12'h400;
    end
  end
  assign base_clk_o = bclk_reg;

  // control pins: pll_reg fields, ring_pd_reg and the divider registers
  assign pll_power_down_o     = pll_reg[`BCG_PLL_PD_BIT];
  assign extra_phase_enable_o = pll_reg[`BCG_PLL_P23_BIT];
  assign pll_direct_o         = pll_reg[`BCG_PLL_DIR_BIT];
  assign pll_post_sel_o       = pll_reg[`BCG_PLL_PSEL_LSB +: 2];
  assign pll_fb_div_o         = pll_reg[`BCG_PLL_M_LSB +: 8];
  assign ring_power_down_o    = ring_pd_reg;
  assign div_src_o            = dsel_reg;
  assign div_l_o              = dl_reg;
  assign div_d_o              = dd_reg;

  // assertions
  property p_safe_ring;
    @(posedge clk_i) disable iff (!rst_n_i)
      osel_reg[0] == 4'h0 && osel_reg[2] == 4'h0;
  endproperty
  a_safe_ring: assert property (p_safe_ring)
    else $error("safe or control clock left ring");

  property p_inact_mask;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_now && avs_address == 8'h0c && avs_byteenable[0] &&
       avs_writedata[3:0] < 4'hc && !src_act[avs_writedata[3:0]])
      |=> osel_reg[3] == $past(osel_reg[3]);
  endproperty
  a_inact_mask: assert property (p_inact_mask)
    else $error("inactive source stored");

  property p_div_nodiv;
    @(posedge clk_i) disable iff (!rst_n_i)
      dsel_reg[0] < BCG_SRC_DIV0;
  endproperty
  a_div_nodiv: assert property (p_div_nodiv)
    else $error("divider fed from divider");

  property p_keep_other;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_now && avs_address == `BCG_OFS_DIVSEL0 && avs_byteenable[1])
      |=> dl_reg[0] == $past(avs_writedata[15:8]);
  endproperty
  a_keep_other: assert property (p_keep_other)
    else $error("other field not written");

  property p_ring_on;
    @(posedge clk_i) disable iff (!rst_n_i) !ring_power_down_o;
  endproperty
  a_ring_on: assert property (p_ring_on)
    else $error("ring oscillator powered down");

  property p_absent_rst;
    @(posedge clk_i) $rose(rst_n_i) |-> src_act == '0;
  endproperty
  a_absent_rst: assert property (p_absent_rst)
    else $error("source present at reset release");

  property p_evt_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      src_fall[1] |=> evt_reg[13];
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("deactivation event lost");

  property p_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
      (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("bus answer late");

  property p_rst_sel;
    @(posedge clk_i) $rose(rst_n_i) |-> osel_reg == '0 && dsel_reg == '0;
  endproperty
  a_rst_sel: assert property (p_rst_sel)
    else $error("select not ring after reset");

  property p_evt_rise;
    @(posedge clk_i) disable iff (!rst_n_i)
      src_rise[0] |=> evt_reg[0];
  endproperty
  a_evt_rise: assert property (p_evt_rise)
    else $error("activation event lost");

endmodule

/* test_bcg_top.sv */
/*
  test_bcg_top: self-checking bench for the base clock generator.
  Assumes the design files are compiled first; every clock source is a
  level that the bench toggles once per control clock cycle while enabled.
*/
`timescale 1ns/10ps
`include "bcg_cfg.svh"
`define CHK_EQ(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

module test_bcg_top
  import bcg_pkg::*;
;
  logic            clk_i;
  logic            rst_n_i;
  logic [7:0]      avs_address;
  logic            avs_read;
  logic            avs_write;
  logic [31:0]     avs_writedata;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic [11:0]     src_lvl;
  logic [11:0]     src_en;
  logic [11:0]     src_hi;
  logic            pll_lock_i;
  logic            pll_power_down_o;
  logic            extra_phase_enable_o;
  logic            pll_direct_o;
  logic [1:0]      pll_post_sel_o;
  logic [7:0]      pll_fb_div_o;
  logic            ring_power_down_o;
  logic [6:0][3:0] div_src_o;
  logic [6:0][7:0] div_l_o;
  logic [6:0][7:0] div_d_o;
  logic [11:0]     base_clk_o;
  int              err_count;
  int              tests_run;
  int              cyc = 0;
  logic [31:0]     rd;
  int              hi;
  int              tog;

  // short lock wait keeps the run brief
  bcg_top #(.LOCK_CYC(4)) i_bcg_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ring_clk_i(src_lvl[0]), .xtal_clk_i(src_lvl[1]),
    .pll_phase_i(src_lvl[4:2]), .div_clk_i(src_lvl[11:5]),
    .pll_lock_i(pll_lock_i), .pll_power_down_o(pll_power_down_o),
    .extra_phase_enable_o(extra_phase_enable_o),
    .pll_direct_o(pll_direct_o), .pll_post_sel_o(pll_post_sel_o),
    .pll_fb_div_o(pll_fb_div_o), .ring_power_down_o(ring_power_down_o),
    .div_src_o(div_src_o), .div_l_o(div_l_o), .div_d_o(div_d_o),
    .base_clk_o(base_clk_o)
  );

  always #25 clk_i = ~clk_i;

  // sources as levels; a stopped source may be parked high
  always @(posedge clk_i) begin
    src_lvl <= (src_lvl ^ src_en) | src_hi;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [7:0] out_ofs(input int n);
    return `BCG_OFS_OUTSEL0 + 8'(4 * n);
  endfunction

  task automatic watch(input int idx, input int n);
    logic last;
    hi  = 0;
    tog = 0;
    last = base_clk_o[idx];
    repeat (n) begin
      @(posedge clk_i);
      if (base_clk_o[idx] === 1'b1) hi++;
      if (base_clk_o[idx] !== last) tog++;
      last = base_clk_o[idx];
    end
  endtask

  task automatic t_reset;
    bus(1'b0, `BCG_OFS_PRESENCE, 32'h0);
    `CHK_EQ(rd[11:0], 12'h000)
    bus(1'b0, out_ofs(1), 32'h0);
    `CHK_EQ(rd[3:0], 4'h0)
    bus(1'b0, `BCG_OFS_DIVSEL0, 32'h0);
    `CHK_EQ(rd[3:0], 4'h0)
    bus(1'b0, `BCG_OFS_PLL_CTRL, 32'h0);
    `CHK_EQ(rd, `BCG_PLL_CTRL_RST)
    `CHK_EQ(pll_power_down_o, 1'b1)
    `CHK_EQ(ring_power_down_o, 1'b0)
    repeat (40) @(posedge clk_i);
    bus(1'b0, `BCG_OFS_PRESENCE, 32'h0);
    `CHK_EQ(rd[11:0], 12'hfff)
    $display("test reset done");
  endtask

  task automatic t_fixed;
    int n[3] = '{0, 2, 10};
    foreach (n[i]) begin
      bus(1'b1, out_ofs(n[i]), 32'h1);
      bus(1'b0, out_ofs(n[i]), 32'h0);
      `CHK_EQ(rd[3:0], 4'h0)
    end
    `CHK_EQ(base_clk_o[10], 1'b0)
    $display("test fixed outputs done");
  endtask

  task automatic t_stop;
    bus(1'b0, `BCG_OFS_PRESENCE, 32'h0);
    if (rd[1] === 1'b1) bus(1'b1, out_ofs(1), 32'h1);
    bus(1'b0, out_ofs(1), 32'h0);
    `CHK_EQ(rd[3:0], 4'h1)
    src_en[1] <= 1'b0;
    repeat (40) @(posedge clk_i);
    bus(1'b0, `BCG_OFS_PRESENCE, 32'h0);
    `CHK_EQ(rd[1], 1'b0)
    bus(1'b0, `BCG_OFS_EVENT, 32'h0);
    `CHK_EQ(rd[13], 1'b1)
    bus(1'b0, out_ofs(1), 32'h0);
    `CHK_EQ(rd[3:0], 4'h1)
    bus(1'b1, `BCG_OFS_EVENT, 32'h2000);
    bus(1'b0, `BCG_OFS_EVENT, 32'h0);
    `CHK_EQ(rd[13], 1'b0)
    bus(1'b1, out_ofs(3), 32'h1);
    bus(1'b0, out_ofs(3), 32'h0);
    `CHK_EQ(rd[3:0], 4'h0)
    src_en[1] <= 1'b1;
    repeat (40) @(posedge clk_i);
    bus(1'b1, out_ofs(3), 32'h1);
    bus(1'b0, out_ofs(3), 32'h0);
    `CHK_EQ(rd[3:0], 4'h1)
    $display("test activity done");
  endtask

  task automatic t_div;
    bus(1'b1, `BCG_OFS_DIVSEL0, 32'h0034_1205);
    bus(1'b0, `BCG_OFS_DIVSEL0, 32'h0);
    `CHK_EQ(rd[3:0], 4'h0)
    `CHK_EQ(div_l_o[0], 8'h12)
    `CHK_EQ(div_d_o[0], 8'h34)
    bus(1'b1, `BCG_OFS_DIVSEL0 + 8'h04, 32'h0000_0003);
    `CHK_EQ(div_src_o[1], 4'h3)
    $display("test divider done");
  endtask

  task automatic t_pll;
    logic [1:0] p;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      bus(1'b1, `BCG_OFS_PLL_CTRL,
          {16'h0, 8'h20 + 8'(i), 3'h0, p, p[0], p[1], 1'b0});
      `CHK_EQ(pll_post_sel_o, p)
      `CHK_EQ(pll_direct_o, p[0])
      `CHK_EQ(extra_phase_enable_o, p[1])
      `CHK_EQ(pll_fb_div_o, 8'h20 + 8'(i))
      `CHK_EQ(pll_power_down_o, 1'b0)
    end
    bus(1'b1, `BCG_OFS_PLL_CTRL, 32'h1);
    `CHK_EQ(pll_power_down_o, 1'b1)
    bus(1'b1, `BCG_OFS_PLL_CTRL, 32'h0);
    bus(1'b1, out_ofs(5), {28'h0, BCG_SRC_PLL0});
    watch(5, 20);
    `CHK_EQ(hi, 0)
    pll_lock_i <= 1'b1;
    bus(1'b0, `BCG_OFS_PLL_STAT, 32'h0);
    `CHK_EQ(rd[0], 1'b1)
    watch(5, 60);
    `CHK_EQ(tog > 0, 1'b1)
    $display("test pll done");
  endtask

  task automatic t_stuck;
    bus(1'b1, out_ofs(6), {28'h0, BCG_SRC_XTAL});
    watch(6, 20);
    `CHK_EQ(tog > 0, 1'b1)
    src_en[1] <= 1'b0;
    src_hi[1] <= 1'b1;
    repeat (2) @(posedge clk_i);
    bus(1'b1, out_ofs(6), {28'h0, BCG_SRC_RING});
    watch(6, 80);
    `CHK_EQ(tog > 1, 1'b1)
    $display("test stuck source done");
  endtask

  initial begin
    clk_i         = 1'b0;
    rst_n_i       = 1'b0;
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    src_lvl       = 12'h000;
    src_en        = 12'hfff;
    src_hi        = 12'h000;
    pll_lock_i    = 1'b0;
    err_count     = 0;
    tests_run     = 0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_fixed();
    t_stop();
    t_div();
    t_pll();
    t_stuck();
    summarize();
  end
endmodule
